/* rtl/i2c_slave_rx_defines.vh */
// Purpose: constants for the two-wire slave receiver
// Assumes: 10 MHz system clock, bus clock sampled as a plain input
// Notes: header bit positions, reset, quirk and glitch constants live here
//
// Behaviour
// - Receive buffer loads every bus byte but own reserved lower address bytes, even unaddressed; overflow flag reports it.
// - While overflow stands, the last valid data byte raises no slave event.
// - A read of the receive buffer clears the buffer-full flag unless a byte loads in the same cycle.
// - Own address byte sets event flag and irq even with full and overflow set.
// - Address after foreign overflow: data flag clear; lost data byte: both set.
// - 10-bit slaves sharing the header top bits all acknowledge the header byte.
// - Own-address reserved lower address byte forms skip buffer-full and load; four forms and 0x102 exempt.
// - Own address 0x102 captures 0x01 as lower address byte, still acknowledged.
// - Turning the module on glitches both bus lines low briefly.
// - Turning the module on forces start-seen to 1 and stop-seen to 0.
`ifndef I2C_SLAVE_RX_DEFINES_VH
`define I2C_SLAVE_RX_DEFINES_VH
// First byte of a 10-bit address: 11110 pattern in bits 7..3
`define TENBIT_HDR 5'h1e
`define TENBIT_HDR_HI 7
`define TENBIT_HDR_LO 3
// Reset values
`define RESET_BYTE 8'h00
// Address 0x102 quirk
`define QUIRK_ADDR 10'h102
`define QUIRK_BYTE 8'h01
// Enable glitch length: 200 ns, two cycles of the 100 ns clock
`define GLITCH_CYC 2'h2
`define GLITCH_W 2
`endif

/* rtl/bit_sampler.v */
// Purpose: synchronise one bus line and report its edges
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module bit_sampler (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Line
  input wire din,
  output reg level_r,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;

  // Two-stage synchroniser then one history stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      level_r <= 1'b1;
    end else if (ce) begin
      meta_r <= din;
      sync_r <= meta_r;
      level_r <= sync_r;
    end
  end

  // Edges between synced and history stage
  assign rise = ce & sync_r & ~level_r;
  assign fall = ce & ~sync_r & level_r;
endmodule // bit_sampler

/* rtl/i2c_slave_rx.v */
// Purpose: two-wire slave receiver, 7/10-bit address, as the silicon behaves
// Assumes: bus lines are open drain; enables high mean pull low
// Notes: ack of data bytes only while addressed; no transmit datapath
`timescale 1ns/1ps
`include "i2c_slave_rx_defines.vh"
module i2c_slave_rx (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Bus clock line
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  // Bus data line
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // Control
  input wire module_on,
  input wire ten_bit_mode,
  input wire [9:0] own_addr,
  input wire rcv_read,
  input wire ovf_clear,
  input wire event_clear,
  // Status
  output reg [7:0] receive_buffer_reg,
  output reg receive_buffer_full,
  output reg receive_overflow_flag,
  output reg slave_event_flag,
  output wire slave_event_irq_flag,
  output reg data_not_addr,
  output reg start_seen,
  output reg stop_seen,
  output reg addressed
);
  localparam ST_IDLE = 2'd0;
  localparam ST_BITS = 2'd1;
  localparam ST_ACK = 2'd2;
  localparam ST_SKIP = 2'd3;

  wire scl_s, scl_rise, scl_fall;
  wire sda_s, sda_rise, sda_fall;
  reg [1:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [1:0] byte_idx_r;
  reg hdr_ok_r;
  reg ack_r;
  reg on_d_r;
  reg [`GLITCH_W-1:0] glitch_r;

  bit_sampler u_scl (
    .clk(clk), .rst_n(rst_n), .ce(ce), .din(scl_i),
    .level_r(scl_s), .rise(scl_rise), .fall(scl_fall)
  );
  bit_sampler u_sda (
    .clk(clk), .rst_n(rst_n), .ce(ce), .din(sda_i),
    .level_r(sda_s), .rise(sda_rise), .fall(sda_fall)
  );

  // Reserved lower byte forms XX0000XXXX / XX1111XXXX, four exempt
  function reserved_low;
    input [9:0] a;
    begin
      reserved_low = ((a[7:4] == 4'h0) || (a[7:4] == 4'hf)) &&
        !((a[9:1] == 9'h078) || (a[9:1] == 9'h0f9) ||
          (a[9:1] == 9'h17a) || (a[9:1] == 9'h1fb));
    end
  endfunction

  wire start_cond = scl_s & sda_fall;
  wire stop_cond = scl_s & sda_rise;
  wire on_rise = module_on & ~on_d_r;
  wire byte_done = scl_rise & (bit_cnt_r == 4'd7);
  wire [7:0] byte_in = {shift_r[6:0], sda_s};
  wire hdr_match = byte_in[`TENBIT_HDR_HI:`TENBIT_HDR_LO] == `TENBIT_HDR &&
    byte_in[2:1] == own_addr[9:8];
  wire addr7_match = byte_in[7:1] == own_addr[6:0];
  wire low_match = hdr_ok_r && byte_in == own_addr[7:0];
  // Byte classification at the eighth bit
  wire is_first = byte_done && byte_idx_r == 2'd0;
  wire is_low = byte_done && byte_idx_r == 2'd1 && ten_bit_mode;
  wire addr_hit = ten_bit_mode ? (is_low && low_match) :
    (is_first && addr7_match);
  wire is_data = byte_done && addressed && !addr_hit &&
    !(is_first && ten_bit_mode);
  // Only own-address matches skip; 0x102 still loads its quirk byte
  wire skip_load = is_low && low_match && (own_addr != `QUIRK_ADDR) &&
    reserved_low({own_addr[9:8], byte_in});
  wire load = byte_done && !skip_load;
  wire [7:0] load_byte = (addr_hit && own_addr == `QUIRK_ADDR) ?
    `QUIRK_BYTE : byte_in;

  // Module-on edge and enable glitch timer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_d_r <= 1'b0;
      glitch_r <= {`GLITCH_W{1'b0}};
    end else if (ce) begin
      on_d_r <= module_on;
      if (on_rise)
        glitch_r <= `GLITCH_CYC;
      else if (glitch_r != {`GLITCH_W{1'b0}})
        glitch_r <= glitch_r - 1'b1;
    end
  end

  // Bit engine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'd0;
      shift_r <= `RESET_BYTE;
      byte_idx_r <= 2'd0;
      hdr_ok_r <= 1'b0;
      ack_r <= 1'b0;
      addressed <= 1'b0;
    end else if (ce) begin
      if (!module_on) begin
        state_r <= ST_IDLE;
        ack_r <= 1'b0;
        addressed <= 1'b0;
      end else if (start_cond) begin
        state_r <= ST_BITS;
        bit_cnt_r <= 4'd0;
        byte_idx_r <= 2'd0;
        hdr_ok_r <= 1'b0;
        ack_r <= 1'b0;
        addressed <= 1'b0;
      end else if (stop_cond) begin
        state_r <= ST_IDLE;
        ack_r <= 1'b0;
        addressed <= 1'b0;
      end else begin
        case (state_r)
          ST_BITS: begin
            if (scl_rise) begin
              shift_r <= byte_in;
              bit_cnt_r <= bit_cnt_r + 4'd1;
            end
            if (byte_done) begin
              state_r <= ST_ACK;
              if (byte_idx_r != 2'd2)
                byte_idx_r <= byte_idx_r + 2'd1;
              // header top bits first, then full low byte
              if (is_first && ten_bit_mode)
                hdr_ok_r <= hdr_match;
              if (addr_hit)
                addressed <= 1'b1;
            end
          end
          ST_ACK: begin
            // Drive ack after falling edge of eighth clock
            if (scl_fall) begin
              ack_r <= addressed || (hdr_ok_r && byte_idx_r == 2'd1);
              state_r <= ST_SKIP;
            end
          end
          ST_SKIP: begin
            if (scl_fall) begin
              ack_r <= 1'b0;
              bit_cnt_r <= 4'd0;
              state_r <= ST_BITS;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Receive buffer, full and overflow: loads on any byte but own reserved low bytes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_buffer_reg <= `RESET_BYTE;
      receive_buffer_full <= 1'b0;
      receive_overflow_flag <= 1'b0;
    end else if (ce) begin
      if (load && state_r == ST_BITS && module_on) begin
        if (receive_buffer_full)
          receive_overflow_flag <= 1'b1;
        else
          receive_buffer_reg <= load_byte;
        receive_buffer_full <= 1'b1;
      end else if (rcv_read) begin
        receive_buffer_full <= 1'b0;
      end
      if (ovf_clear && !(load && receive_buffer_full))
        receive_overflow_flag <= 1'b0;
    end
  end

  // Slave event flag and data-not-address flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_event_flag <= 1'b0;
      data_not_addr <= 1'b0;
    end else if (ce) begin
      if (byte_done && state_r == ST_BITS && module_on && addr_hit) begin
        slave_event_flag <= 1'b1;
        data_not_addr <= 1'b0;
      end else if (byte_done && state_r == ST_BITS && module_on &&
          is_data) begin
        data_not_addr <= 1'b1;
        if (!receive_overflow_flag && !receive_buffer_full)
          slave_event_flag <= 1'b1;
        else if (event_clear)
          slave_event_flag <= 1'b0;
      end else if (event_clear) begin
        slave_event_flag <= 1'b0;
      end
    end
  end

  assign slave_event_irq_flag = slave_event_flag;

  // Start and stop status, forced on module enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else if (ce) begin
      if (on_rise) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end else if (module_on && start_cond) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end else if (module_on && stop_cond) begin
        start_seen <= 1'b0;
        stop_seen <= 1'b1;
      end
    end
  end

  // Open-drain drive: ack pulls data; glitch pulls both
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = ack_r | (glitch_r != {`GLITCH_W{1'b0}});
  assign scl_oe = (glitch_r != {`GLITCH_W{1'b0}});
endmodule // i2c_slave_rx

/* test/i2c_slave_rx_properties.sv */
// Purpose: timing checks on the slave receiver ports
// Assumes: single clock domain
// Notes: bound into every receiver instance
`timescale 1ns/1ps
module i2c_slave_rx_properties (
  // Clock, reset, control
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire module_on,
  input wire ovf_clear,
  input wire event_clear,
  // Outputs watched
  input wire scl_oe,
  input wire sda_oe,
  input wire receive_overflow_flag,
  input wire slave_event_flag,
  input wire slave_event_irq_flag,
  input wire data_not_addr,
  input wire start_seen,
  input wire stop_seen,
  input wire addressed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Enable forces start status and pulls both lines
  a_enable_status: assert property (ce && $rose(module_on) |-> ##[1:2]
    (start_seen && !stop_seen)) else $error("start status not forced");
  a_enable_glitch: assert property (ce && $rose(module_on) |-> ##[1:2]
    (sda_oe && scl_oe)) else $error("no glitch on enable");
  a_glitch_length: assert property ($rose(scl_oe) |=> scl_oe ##1 !scl_oe)
    else $error("clock pull not two cycles");
  a_idle_quiet: assert property (!module_on && !$past(module_on) |->
    !sda_oe && !scl_oe) else $error("lines pulled while off");
  a_irq_copy: assert property (slave_event_irq_flag == slave_event_flag)
    else $error("irq differs from event flag");
  a_event_held: assert property (slave_event_flag && !event_clear |=>
    slave_event_flag) else $error("event flag lost");
  a_overflow_held: assert property (receive_overflow_flag && !ovf_clear
    |=> receive_overflow_flag) else $error("overflow flag lost");
  a_event_addressed: assert property ($rose(slave_event_flag) |->
    addressed) else $error("event without match");
  a_event_ovf_addr: assert property ($rose(slave_event_flag) &&
    receive_overflow_flag |-> !data_not_addr) else $error("data event in ovf");
  // Main scenarios reached
  c_event: cover property ($rose(slave_event_flag));
  c_overflow: cover property ($rose(receive_overflow_flag));
  c_ack: cover property ($rose(sda_oe) && module_on);
endmodule // i2c_slave_rx_properties
bind i2c_slave_rx i2c_slave_rx_properties chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .module_on(module_on),
  .ovf_clear(ovf_clear), .event_clear(event_clear),
  .scl_oe(scl_oe), .sda_oe(sda_oe),
  .receive_overflow_flag(receive_overflow_flag),
  .slave_event_flag(slave_event_flag),
  .slave_event_irq_flag(slave_event_irq_flag),
  .data_not_addr(data_not_addr), .start_seen(start_seen),
  .stop_seen(stop_seen), .addressed(addressed)
);

/* test/bus_master_model.sv */
// Purpose: other master on the shared two-wire bus
// Assumes: lines are open drain with pull-ups
// Notes: clock stands high outside frames, 800 ns per bit
`timescale 1ns/1ps
module bus_master_model (
  // Resolved lines
  input wire scl,
  input wire sda,
  // Pull-downs
  output reg scl_pull,
  output reg sda_pull
);
  // Released bus
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Start: data falls while clock high
  task start;
    begin
      sda_pull = 1'b1;
      #400 scl_pull = 1'b1;
    end
  endtask
  // Eight bits, high bit first, then ack clock
  task send_byte(input [7:0] b, output reg ack);
    integer i;
    begin
      for (i = 7; i >= -1; i = i - 1) begin
        #200 sda_pull = (i >= 0) ? !b[i] : 1'b0;
        #200 scl_pull = 1'b0;
        #200 if (i < 0) ack = !sda;
        #200 scl_pull = 1'b1;
      end
    end
  endtask
  // Stop: data rises while clock high
  task stop;
    begin
      #200 sda_pull = 1'b1;
      #200 scl_pull = 1'b0;
      #400 sda_pull = 1'b0;
      #800;
    end
  endtask
endmodule // bus_master_model

/* test/tb_top.sv */
// Purpose: self-checking bench for the two-wire slave receiver
// Assumes: ce held high, one master model on the bus
// Notes: control pulses change at the falling clock edge
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg module_on = 1'b0;
  reg ten_bit_mode = 1'b0;
  reg [9:0] own_addr = 10'h055;
  reg pin_hold = 1'b0;
  reg rcv_read = 1'b0;
  reg ovf_clear = 1'b0;
  reg event_clear = 1'b0;
  reg ack = 1'b0;
  integer fail_count = 0;
  integer check_count = 0;
  integer i;
  wire ce = 1'b1;
  wire scl_pull, sda_pull, scl_o, sda_o, scl_oe, sda_oe;
  wire receive_buffer_full, receive_overflow_flag, slave_event_flag;
  wire slave_event_irq_flag, data_not_addr, start_seen, stop_seen;
  wire addressed;
  wire [7:0] receive_buffer_reg;
  // Open-drain lines with pull-ups; pin_hold lends pins to another user
  wire scl_i = pin_hold | !(scl_pull | scl_oe);
  wire sda_i = pin_hold | !(sda_pull | sda_oe);
  always #50 clk = !clk;
  bus_master_model m (.scl(scl_i), .sda(sda_i), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  i2c_slave_rx dut (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .module_on(module_on), .ten_bit_mode(ten_bit_mode),
    .own_addr(own_addr), .rcv_read(rcv_read), .ovf_clear(ovf_clear),
    .event_clear(event_clear), .receive_buffer_reg(receive_buffer_reg),
    .receive_buffer_full(receive_buffer_full),
    .receive_overflow_flag(receive_overflow_flag),
    .slave_event_flag(slave_event_flag),
    .slave_event_irq_flag(slave_event_irq_flag),
    .data_not_addr(data_not_addr), .start_seen(start_seen),
    .stop_seen(stop_seen), .addressed(addressed)
  );
  // Compare and count
  task check(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Full, overflow, event flags together
  task stat(input [2:0] e);
    check("flags", 8'({receive_buffer_full, receive_overflow_flag,
      slave_event_flag}), 8'(e));
  endtask
  // One-cycle pulse: read, overflow clear, event clear
  task pulse(input [2:0] p);
    begin
      @(negedge clk) {rcv_read, ovf_clear, event_clear} = p;
      @(negedge clk) {rcv_read, ovf_clear, event_clear} = 3'h0;
    end
  endtask
  // Finish a frame and let flags settle
  task end_frame;
    begin
      m.stop;
      repeat (4) @(negedge clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    print_verdict;
  end
  // Test sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk) module_on = 1'b1;
    repeat (2) @(negedge clk);
    check("status", 8'({start_seen, stop_seen}), 8'h02);
    check("odrv", 8'({scl_o, sda_o}), 8'h00);
    #1600;
    $display("test enable done");
    m.start;
    m.send_byte(8'ha0, ack);
    m.send_byte(8'h3c, ack);
    end_frame;
    check("ack", 8'(ack), 8'h00);
    check("buffer", receive_buffer_reg, 8'ha0);
    stat(3'h6);
    m.start;
    m.send_byte(8'haa, ack);
    end_frame;
    check("ack", 8'(ack), 8'h01);
    stat(3'h7);
    check("irq", 8'(slave_event_irq_flag), 8'h01);
    check("dna", 8'(data_not_addr), 8'h00);
    pulse(3'h7);
    stat(3'h0);
    m.start;
    m.send_byte(8'haa, ack);
    pulse(3'h1);
    m.send_byte(8'h5a, ack);
    end_frame;
    check("buffer", receive_buffer_reg, 8'haa);
    stat(3'h6);
    check("dna", 8'(data_not_addr), 8'h01);
    $display("test overflow done");
    pulse(3'h7);
    own_addr = 10'h102;
    ten_bit_mode = 1'b1;
    m.start;
    m.send_byte(8'hf2, ack);
    check("ack", 8'(ack), 8'h01);
    pulse(3'h5);
    m.send_byte(8'h02, ack);
    check("match", 8'(addressed), 8'h01);
    end_frame;
    check("ack", 8'(ack), 8'h01);
    check("buffer", receive_buffer_reg, 8'h01);
    $display("test ten bit done");
    for (i = 0; i < 2; i = i + 1) begin
      pulse(3'h7);
      own_addr = i ? 10'h0f0 : 10'h005;
      m.start;
      m.send_byte(8'hf0, ack);
      pulse(3'h4);
      m.send_byte(own_addr[7:0], ack);
      end_frame;
      check("full", 8'(receive_buffer_full), 8'(i));
    end
    $display("test reserved done");
    // Re-enable while a higher-precedence user holds the pins
    check("status", 8'({start_seen, stop_seen}), 8'h01);
    @(negedge clk) module_on = 1'b0;
    pin_hold = 1'b1;
    @(negedge clk) module_on = 1'b1;
    @(negedge clk) check("pull", 8'({scl_oe, sda_oe}), 8'h03);
    check("status", 8'({start_seen, stop_seen}), 8'h02);
    repeat (16) @(negedge clk);
    check("pull", 8'({scl_oe, sda_oe}), 8'h00);
    pin_hold = 1'b0;
    $display("test re-enable done");
    print_verdict;
  end
endmodule // tb_top
